// >>> rtl/frame_error_stats.sv
// Frame error statistics counters of the MAC with their register port.
// Assumes rx_done and rx_frame come from the receive datapath on clk,
// and tx_underrun from the transmit DMA on clk; PHY pins are asynchronous.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "stats_params.svh"
module frame_error_stats #(parameter int COUNT_WIDTH = 8)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic rx_dv,
	input wire logic rx_er,
	input wire logic tx_en,
	input wire logic collision_input,
	input wire logic rx_done,
	input wire stats_pkg::rx_frame_t rx_frame,
	input wire logic tx_underrun,
	output logic fcs_align_event
);
	localparam int N = `NUM_COUNTERS;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] pins;
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	logic rx_dv_s;
	logic rx_er_s;
	logic tx_en_s;
	logic collision_s;

	assign pins = {collision_input, tx_en, rx_er, rx_dv};

	// Each pin passes two flops so that no logic sees a metastable level.
	genvar p;
	generate
		for (p = 0; p < 4; p++)
		begin : g_sync
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					pin_meta[p] <= 1'b0;
					pin_sync[p] <= 1'b0;
				end
				else if (ce)
				begin
					pin_meta[p] <= pins[p];
					pin_sync[p] <= pin_meta[p];
				end
			end
		end
	endgenerate

	assign rx_dv_s = pin_sync[0];
	assign rx_er_s = pin_sync[1];
	assign tx_en_s = pin_sync[2];
	assign collision_s = pin_sync[3];

	// ------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------
	stats_pkg::net_config_t cfg;
	logic [31:0] cfg_word;

	// Only the four implemented bits are kept; the rest read as zero.
	always_ff @(posedge clk)
	begin
		if (rst)
			cfg <= '0;
		else if (ce && wr && addr == `OFS_CONFIG)
		begin
			cfg.speed100 <= wdata[`CFG_SPEED100_BIT];
			cfg.full_duplex <= wdata[`CFG_FULL_DUPLEX_BIT];
			cfg.big_frames <= wdata[`CFG_BIG_FRAME_BIT];
			cfg.len_check <= wdata[`CFG_LEN_CHECK_BIT];
		end
	end

	always_comb
	begin
		cfg_word = 32'h0000_0000;
		cfg_word[`CFG_SPEED100_BIT] = cfg.speed100;
		cfg_word[`CFG_FULL_DUPLEX_BIT] = cfg.full_duplex;
		cfg_word[`CFG_BIG_FRAME_BIT] = cfg.big_frames;
		cfg_word[`CFG_LEN_CHECK_BIT] = cfg.len_check;
	end

	// ------------------------------------------------------------
	// Receive symbol error tracking
	// ------------------------------------------------------------
	logic sym_seen;
	logic sym_now;

	// An error in the closing cycle still belongs to the ending frame.
	assign sym_now = sym_seen | (rx_dv_s & rx_er_s);

	always_ff @(posedge clk)
	begin
		if (rst)
			sym_seen <= 1'b0;
		else if (ce)
		begin
			if (rx_done)
				sym_seen <= 1'b0;
			else if (rx_dv_s && rx_er_s)
				sym_seen <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Frame classification
	// ------------------------------------------------------------
	logic [13:0] max_len;
	logic over;
	logic under;
	logic any_err;
	logic type_frame;
	logic [13:0] payload;
	logic mismatch;
	logic [N-1:0] next_inc;
	logic [N-1:0] inc;
	logic heartbeat;

	assign max_len = cfg.big_frames ? `MAX_BIG_FRAME_BYTES
		: `MAX_FRAME_BYTES;
	assign over = rx_frame.length > max_len;
	assign under = rx_frame.length < `MIN_FRAME_BYTES;
	assign any_err = rx_frame.crc_error | rx_frame.align_error | sym_now;
	assign type_frame = rx_frame.length_type >= `TYPE_ID_MIN;
	// The length field counts payload bytes, so header and FCS come off.
	assign payload = (rx_frame.length > `HDR_FCS_BYTES)
		? rx_frame.length - `HDR_FCS_BYTES : 14'h0000;
	assign mismatch = cfg.len_check && !type_frame && !over
		&& ({2'h0, payload} < rx_frame.length_type);

	// Increments are registered so that each counter sees one clean pulse.
	always_comb
	begin
		next_inc = '0;
		next_inc[stats_pkg::CNT_SYMBOL] = rx_done && sym_now;
		next_inc[stats_pkg::CNT_OVERLENGTH] = rx_done && over
			&& !any_err;
		next_inc[stats_pkg::CNT_JABBER] = rx_done && over
			&& any_err;
		next_inc[stats_pkg::CNT_SHORT] = rx_done && under
			&& !any_err;
		next_inc[stats_pkg::CNT_HEARTBEAT] = heartbeat;
		next_inc[stats_pkg::CNT_MISMATCH] = rx_done && mismatch;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			inc <= '0;
			fcs_align_event <= 1'b0;
		end
		else if (ce)
		begin
			inc <= next_inc;
			fcs_align_event <= rx_done && sym_now && !over
				&& !under;
		end
	end

	// ------------------------------------------------------------
	// Collision test monitor
	// ------------------------------------------------------------
	sqe_monitor u_sqe
	(
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.tx_en(tx_en_s),
		.collision_input(collision_s),
		.underrun(tx_underrun),
		.half_duplex(!cfg.full_duplex),
		.speed100(cfg.speed100),
		.sqe_error(heartbeat)
	);

	// ------------------------------------------------------------
	// Counters and register reads
	// ------------------------------------------------------------
	logic [COUNT_WIDTH-1:0] counts [N];
	logic [7:0] rel;
	logic [2:0] idx;
	logic count_hit;

	assign rel = addr - `OFS_FIRST_COUNT;
	assign idx = rel[4:2];
	// Only word-aligned offsets inside the counter block select a counter.
	assign count_hit = addr >= `OFS_FIRST_COUNT && rel[1:0] == 2'h0
		&& rel[7:5] == 3'h0 && int'(idx) < N;

	genvar c;
	generate
		for (c = 0; c < N; c++)
		begin : g_count
			stat_counter #(.WIDTH(COUNT_WIDTH)) u_count
			(
				.clk(clk),
				.rst(rst),
				.ce(ce),
				.inc(inc[c]),
				.load(wr && count_hit && int'(idx) == c),
				.load_value(wdata[COUNT_WIDTH-1:0]),
				.count(counts[c])
			);
		end
	endgenerate

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge clk)
	begin
		if (rst)
			rdata <= 32'h0000_0000;
		else if (ce)
		begin
			if (rd && addr == `OFS_CONFIG)
				rdata <= cfg_word;
			else if (rd && count_hit)
				rdata <= 32'(counts[idx]);
			else
				rdata <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_symbol_counted: assert property (
		ce && rx_done && sym_now |=> inc[stats_pkg::CNT_SYMBOL])
		else $error("symbol error frame not counted");
	a_symbol_clean: assert property (
		ce && rx_done && !sym_now |=> !inc[stats_pkg::CNT_SYMBOL])
		else $error("frame without symbol error counted");
	a_symbol_sticky: assert property (
		ce && !rx_done && rx_dv_s && rx_er_s |=> sym_seen)
		else $error("symbol error not remembered");
	a_fcs_also: assert property (
		ce && rx_done && sym_now && !over && !under
		|=> fcs_align_event)
		else $error("symbol error frame missed the FCS event");
	a_fcs_legal_only: assert property (
		ce && rx_done && (over || under) |=> !fcs_align_event)
		else $error("FCS event for a frame of illegal length");
	a_jabber_not_fcs: assert property (
		ce && rx_done && sym_now && over
		|=> inc[stats_pkg::CNT_JABBER] && !fcs_align_event)
		else $error("overlong symbol frame misclassified");
	a_overlength_clean: assert property (
		ce && rx_done |=> inc[stats_pkg::CNT_OVERLENGTH]
		== $past(over && !any_err))
		else $error("excessive length count wrong");
	a_jabber_crc: assert property (
		ce && rx_done && over && rx_frame.crc_error
		|=> inc[stats_pkg::CNT_JABBER]
		&& !inc[stats_pkg::CNT_OVERLENGTH])
		else $error("jabber frame not counted");
	a_long_exclusive: assert property (
		ce && rx_done && over |=> inc[stats_pkg::CNT_JABBER]
		!= inc[stats_pkg::CNT_OVERLENGTH])
		else $error("overlong frame not counted exactly once");
	a_legal_not_long: assert property (
		ce && rx_done && !over |=> !inc[stats_pkg::CNT_JABBER]
		&& !inc[stats_pkg::CNT_OVERLENGTH])
		else $error("frame of legal length counted as overlong");
	a_short_frame: assert property (
		ce && rx_done |=> inc[stats_pkg::CNT_SHORT]
		== $past(under && !any_err))
		else $error("undersize count wrong");
	a_mismatch_off: assert property (
		ce && !cfg.len_check |=> !inc[stats_pkg::CNT_MISMATCH])
		else $error("mismatch counted while checking is off");
	a_mismatch_type: assert property (
		ce && rx_done && (type_frame || over)
		|=> !inc[stats_pkg::CNT_MISMATCH])
		else $error("type or overlong frame counted as mismatch");
	a_mismatch_count: assert property (
		ce && rx_done && cfg.len_check && !type_frame && !over
		&& ({2'h0, payload} < rx_frame.length_type)
		|=> inc[stats_pkg::CNT_MISMATCH] ##1
		counts[stats_pkg::CNT_MISMATCH] != $past(
		counts[stats_pkg::CNT_MISMATCH], 2) || !$past(ce))
		else $error("length mismatch not counted");
	a_mismatch_none: assert property (
		ce && rx_done && ({2'h0, payload} >= rx_frame.length_type)
		|=> !inc[stats_pkg::CNT_MISMATCH])
		else $error("frame of full length counted as mismatch");

	// ------------------------------------------------------------
	// Transmit test checks
	// ------------------------------------------------------------
	a_sqe_sync: assert property (
		inc[stats_pkg::CNT_HEARTBEAT] && $past(ce) |-> $past(heartbeat))
		else $error("test error count without monitor pulse");
	a_sqe_pulse: assert property (
		ce && heartbeat |=> !heartbeat)
		else $error("test error pulse stood longer than one cycle");

	// ------------------------------------------------------------
	// Register port checks
	// ------------------------------------------------------------
	a_cfg_write: assert property (
		ce && wr && addr == `OFS_CONFIG
		|=> cfg.len_check == $past(wdata[`CFG_LEN_CHECK_BIT])
		&& cfg.big_frames == $past(wdata[`CFG_BIG_FRAME_BIT]))
		else $error("configuration write lost");
	a_read_cfg: assert property (
		ce && rd && addr == `OFS_CONFIG |=> rdata == $past(cfg_word))
		else $error("configuration read wrong");
	a_read_count: assert property (
		ce && rd && count_hit
		|=> rdata[COUNT_WIDTH-1:0] == $past(counts[idx]))
		else $error("counter read wrong");
	a_read_upper: assert property (
		ce && rd && count_hit |=> rdata[31:COUNT_WIDTH] == '0)
		else $error("counter read shows upper bits");
	a_read_idle: assert property (
		ce && !rd |=> rdata == 32'h0000_0000)
		else $error("read data stood outside the read cycle");

	// ------------------------------------------------------------
	// Coverage
	// ------------------------------------------------------------
	c_jabber: cover property (ce && rx_done && over && sym_now);
	c_short: cover property (ce && rx_done && under && !any_err);
	c_heartbeat: cover property (heartbeat);
	c_mismatch: cover property (inc[stats_pkg::CNT_MISMATCH]);
	c_fcs_event: cover property (fcs_align_event);
endmodule

// >>> rtl/stats_params.svh
// Constants of the frame error statistics block: offsets, fields, counts.
// Assumes a 40 MHz clock and one aligned 32-bit word per register.
`ifndef STATS_PARAMS_SVH
`define STATS_PARAMS_SVH
`define CLK_MHZ 40
`define NUM_COUNTERS 6
`define OFS_CONFIG 8'h00
`define OFS_FIRST_COUNT 8'h04
`define CFG_SPEED100_BIT 0
`define CFG_FULL_DUPLEX_BIT 1
`define CFG_BIG_FRAME_BIT 8
`define CFG_LEN_CHECK_BIT 16
`define COUNT_RESET 8'h00
`define MIN_FRAME_BYTES 14'h0040
`define MAX_FRAME_BYTES 14'h05EE
`define MAX_BIG_FRAME_BYTES 14'h0600
`define TYPE_ID_MIN 16'h0600
`define HDR_FCS_BYTES 14'h0012
`define SQE_WINDOW_10_NS 9600
`define SQE_WINDOW_100_NS 960
`define SQE_CYCLES_10 ((`SQE_WINDOW_10_NS * `CLK_MHZ) / 1000)
`define SQE_CYCLES_100 ((`SQE_WINDOW_100_NS * `CLK_MHZ) / 1000)
`endif

// >>> rtl/stats_pkg.sv
// Types shared by the frame error statistics block.
// Assumes nothing beyond a SystemVerilog compiler.
package stats_pkg;
	typedef struct packed {
		logic [13:0] length;
		logic crc_error;
		logic align_error;
		logic [15:0] length_type;
	} rx_frame_t;
	typedef struct packed {
		logic len_check;
		logic big_frames;
		logic full_duplex;
		logic speed100;
	} net_config_t;
	typedef enum logic [2:0] {
		CNT_SYMBOL = 3'h0,
		CNT_OVERLENGTH = 3'h1,
		CNT_JABBER = 3'h2,
		CNT_SHORT = 3'h3,
		CNT_HEARTBEAT = 3'h4,
		CNT_MISMATCH = 3'h5
	} counter_sel_t;
	typedef enum logic [1:0] {
		SQE_IDLE = 2'h0,
		SQE_SEND = 2'h1,
		SQE_WAIT = 2'h3
	} sqe_state_t;
endpackage

// >>> rtl/stat_counter.sv
// One software-writable statistics counter.
// Assumes increment and load come from logic on the same clock.
`timescale 1ns/10ps
`include "stats_params.svh"
module stat_counter #(parameter int WIDTH = 8)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic inc,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_value,
	output logic [WIDTH-1:0] count
);
	// A frame seen in the cycle of a software write is still counted.
	always_ff @(posedge clk)
	begin
		if (rst)
			count <= WIDTH'(`COUNT_RESET);
		else if (ce)
		begin
			if (load)
				count <= load_value + WIDTH'(inc);
			else if (inc)
				count <= count + WIDTH'(1);
		end
	end

	a_count_step: assert property (
		@(posedge clk) disable iff (rst)
		ce && inc && !load |=> count == $past(count) + WIDTH'(1))
		else $error("counter did not step by one");
	a_count_hold: assert property (
		@(posedge clk) disable iff (rst)
		!ce || (!inc && !load) |=> $stable(count))
		else $error("counter moved without an event");
	a_count_load: assert property (
		@(posedge clk) disable iff (rst)
		ce && load |=> count == $past(load_value) + WIDTH'($past(inc)))
		else $error("counter write lost");
endmodule

// >>> rtl/sqe_monitor.sv
// Watches the end of each half-duplex transmission without underrun for the collision test pulse.
// Assumes tx_en and the collision input are already synchronised.
`timescale 1ns/10ps
`include "stats_params.svh"
module sqe_monitor
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic tx_en,
	input wire logic collision_input,
	input wire logic underrun,
	input wire logic half_duplex,
	input wire logic speed100,
	output logic sqe_error
);
	localparam logic [8:0] LIMIT_10 = 9'(`SQE_CYCLES_10);
	localparam logic [8:0] LIMIT_100 = 9'(`SQE_CYCLES_100);
	stats_pkg::sqe_state_t state;
	logic [8:0] waited;
	logic [8:0] limit;
	logic underran;

	assign limit = speed100 ? LIMIT_100 : LIMIT_10;

	always_ff @(posedge clk)
	begin
		if (rst)
			underran <= 1'b0;
		else if (ce)
		begin
			// An underrun at the edge that opens a frame still marks it.
			if (underrun && (state != stats_pkg::SQE_IDLE || tx_en))
				underran <= 1'b1;
			else if (state == stats_pkg::SQE_IDLE)
				underran <= 1'b0;
		end
	end

	// The window closes after 96 bit times, rounded down to whole cycles.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= stats_pkg::SQE_IDLE;
			waited <= 9'h000;
			sqe_error <= 1'b0;
		end
		else if (ce)
		begin
			sqe_error <= 1'b0;
			unique case (state)
				stats_pkg::SQE_IDLE:
					if (tx_en)
						state <= stats_pkg::SQE_SEND;
				stats_pkg::SQE_SEND:
					if (!tx_en)
					begin
						waited <= 9'h000;
						if (underran || underrun || !half_duplex)
							state <= stats_pkg::SQE_IDLE;
						else
							state <= stats_pkg::SQE_WAIT;
					end
				stats_pkg::SQE_WAIT:
					if (collision_input)
						state <= stats_pkg::SQE_IDLE;
					else if (waited == limit - 9'h001)
					begin
						sqe_error <= 1'b1;
						state <= stats_pkg::SQE_IDLE;
					end
					else
						waited <= waited + 9'h001;
				default:
					state <= stats_pkg::SQE_IDLE;
			endcase
		end
	end

	a_sqe_col_clears: assert property (
		@(posedge clk) disable iff (rst)
		ce && state == stats_pkg::SQE_WAIT && collision_input
		|=> !sqe_error)
		else $error("error counted despite collision");
	a_sqe_window: assert property (
		@(posedge clk) disable iff (rst)
		ce && state == stats_pkg::SQE_WAIT && !collision_input
		&& waited == limit - 9'h001 |=> sqe_error)
		else $error("missing collision not reported");
	a_sqe_underrun: assert property (
		@(posedge clk) disable iff (rst)
		ce && state == stats_pkg::SQE_SEND && !tx_en
		&& (underran || underrun) |=> state == stats_pkg::SQE_IDLE)
		else $error("underrun frame opened the test window");
endmodule

// >>> dv/mii_phy_model.sv
// Behavioural PHY on the media independent interface side of the block.
// Assumes the bench calls its tasks from one process clocked by clk.
`timescale 1ns/10ps
module mii_phy_model
(
	input wire logic clk,
	output logic rx_dv,
	output logic rx_er,
	output logic tx_en,
	output logic collision_input
);
	initial
	begin
		rx_dv = 1'b0;
		rx_er = 1'b0;
		tx_en = 1'b0;
		collision_input = 1'b0;
	end
	// Receives n cycles of data, with one error cycle in the middle if err.
	task automatic receive(input int n, input bit err);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			rx_dv <= 1'b1;
			rx_er <= err && (i == n / 2);
		end
		@(posedge clk);
		rx_dv <= 1'b0;
		rx_er <= 1'b0;
	endtask
	// Sends n cycles, then answers with a collision pulse cdel cycles after
	// the end of transmission, or never when cdel is negative.
	task automatic transmit(input int n, input int cdel);
		@(posedge clk);
		tx_en <= 1'b1;
		repeat (n) @(posedge clk);
		tx_en <= 1'b0;
		if (cdel >= 0)
		begin
			repeat (cdel) @(posedge clk);
			collision_input <= 1'b1;
			repeat (2) @(posedge clk);
			collision_input <= 1'b0;
		end
	endtask
endmodule

// >>> dv/frame_error_stats_test.sv
// Self-checking bench of the frame error statistics counters.
// Assumes the design files and the PHY model are compiled before it.
`timescale 1ns/10ps
module frame_error_stats_test;
	logic clk, rst, ce, wr, rd, rx_done, tx_underrun;
	logic rx_dv, rx_er, tx_en, collision_input, fcs_align_event;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, cfg, r;
	stats_pkg::rx_frame_t rx_frame;
	int fail_count = 0;
	int n_checks = 0;
	int seed = 32'hF2C0;
	int e[6];
	int lens[8] = '{63, 64, 1518, 1519, 1536, 1537, 100, 40};
	logic [15:0] lts[4] = '{16'h0600, 16'h05FF, 16'h002E, 16'h0100};

	frame_error_stats #(.COUNT_WIDTH(8)) dut (.clk(clk), .rst(rst), .ce(ce),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.rx_dv(rx_dv), .rx_er(rx_er), .tx_en(tx_en),
		.collision_input(collision_input), .rx_done(rx_done),
		.rx_frame(rx_frame), .tx_underrun(tx_underrun),
		.fcs_align_event(fcs_align_event));
	mii_phy_model phy (.clk(clk), .rx_dv(rx_dv), .rx_er(rx_er),
		.tx_en(tx_en), .collision_input(collision_input));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_evt(input logic got, input logic exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic chk_counts;
		for (int i = 0; i < 6; i++)
			rd_chk(8'h04 + 8'(4 * i), 32'(e[i]) & 32'hFF);
	endtask
	task automatic endt(input string s);
		$display("test %s done", s);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// A received frame, with the model's view of what it should count.
	task automatic frame(input int len, input bit crc, input bit aln,
		input bit sym, input logic [15:0] lt);
		bit over, err;
		over = len > (cfg[8] ? 1536 : 1518);
		err = crc | aln | sym;
		phy.receive(6, sym);
		repeat (3) @(posedge clk);
		rx_frame <= '{length: 14'(len), crc_error: crc, align_error: aln,
			length_type: lt};
		rx_done <= 1'b1;
		@(posedge clk);
		rx_done <= 1'b0;
		#1;
		chk_evt(fcs_align_event, sym && len >= 64 && !over);
		e[0] += sym;
		e[1] += over && !err;
		e[2] += over && err;
		e[3] += len < 64 && !err;
		e[5] += cfg[16] && lt < 16'h0600 && !over
			&& (len > 18 ? len - 18 : 0) < lt;
		repeat (2) @(posedge clk);
		chk_counts();
	endtask

	// A transmission; col 0 none, 1 early, 2 after the window.
	task automatic tx(input logic [31:0] c, input bit und, input int col);
		int win;
		wr_reg(8'h00, c);
		win = c[0] ? 38 : 384;
		tx_underrun <= und;
		phy.transmit(20, col == 0 ? -1 : (col == 1 ? 5 : win + 20));
		tx_underrun <= 1'b0;
		repeat (win + 40) @(posedge clk);
		e[4] += !c[1] && !und && col != 1;
		chk_counts();
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		rx_done = 1'b0;
		tx_underrun = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		rx_frame = '0;
		cfg = 32'h0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd_chk(8'h00, 32'h0);
		chk_counts();
		rd_chk(8'h40, 32'h0);
		endt("reset");
		for (int i = 0; i < 6; i++)
		begin
			e[i] = (i == 2) ? 255 : ($random(seed) & 255);
			wr_reg(8'h04 + 8'(4 * i), {24'($random(seed)), 8'(e[i])});
		end
		chk_counts();
		endt("write");
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(8'h04, 32'h0000_0000);
		ce <= 1'b1;
		chk_counts();
		endt("freeze");
		for (int k = 0; k < 48; k++)
		begin
			if (k % 8 == 0)
			begin
				cfg = {15'h0, 1'($random(seed)), 7'h0, 1'($random(seed)), 8'h0};
				wr_reg(8'h00, cfg);
				rd_chk(8'h00, cfg);
			end
			r = $random(seed);
			frame(lens[r[2:0]], r[3] & r[4], r[5] & r[6], r[7], lts[r[9:8]]);
		end
		endt("receive");
		tx(32'h1, 1'b0, 0);
		tx(32'h1, 1'b0, 1);
		tx(32'h1, 1'b0, 2);
		tx(32'h3, 1'b0, 0);
		tx(32'h1, 1'b1, 0);
		tx(32'h0, 1'b0, 0);
		endt("transmit");
		summarize();
	end

	initial
	begin
		repeat (30000) @(posedge clk);
		fail_count++;
		summarize();
	end
endmodule
